// ### rtl/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map and field positions
// ----------------------------------------------------------------------------
`define WDT_CTRL_OFFSET      12'h000
`define WDT_BIT_FLAG         7
`define WDT_BIT_IRQ_EN       6
`define WDT_BIT_PSEL_HI      5
`define WDT_BIT_CHANGE_EN    4
`define WDT_BIT_RST_EN       3
`define WDT_CTRL_RESET       8'h00
`define WDT_RST_EN_RESET     1'b0
`define WDT_PSEL_RESET       4'h0
`define WDT_PSEL_MAX         4'h9

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDT_CHANGE_EN_CYCLES 3'h4
`define WDT_SYS_CLK_HZ       250000000
`define WDT_OSC_HZ           128000
`define WDT_OSC_DIV          (`WDT_SYS_CLK_HZ / `WDT_OSC_HZ)
`define WDT_CNT_W            21
`define WDT_BASE_TICKS       21'h000800
`define WDT_DIV_W            12

`endif

// ### rtl/wdt_count_if.sv
`timescale 1ns/1ps

interface wdt_count_if;
  logic       restart;
  logic       run;
  logic [3:0] prescale_sel;
  logic       timeout;

  modport ctrl (output restart, output run, output prescale_sel, input timeout);
  modport cnt  (input restart, input run, input prescale_sel, output timeout);
endinterface : wdt_count_if

// ### rtl/wdt_event_sync.sv
`timescale 1ns/1ps

module wdt_event_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic evt,
  output logic      evt_sync
);
  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= evt;
      stage2_q <= stage1_q;
    end
  end

  assign evt_sync = stage2_q;
endmodule : wdt_event_sync

// ### rtl/wdt_mode_control.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

// What this block does
// - Time-out in interrupt operation sets timeout_flag.
// - Executing the watchdog vector clears timeout_flag.
// - Writing one clears timeout_flag; writing zero leaves it.
// - Interrupt request only when flag, irq enable and global enable set.
// - Irq enable without reset enable: interrupt only, no reset.
// - Both enables set: first time-out sets the flag, no reset.
// - Combined mode vector execution clears irq enable and flag.
// - Combined mode, unserviced flag at next time-out resets system.
// - Clock monitoring forces reset mode if fuse or an enable is set, else stopped mode; disables interrupts.
// - Clock monitoring resets if fuse, reset enable or irq enable set.
// - change_en clears itself four clock cycles after being set.
// - Reset cause flag holds reset enable at one.
// - Prescale code picks 2048 shl code ticks; codes above 1001 reserved.
// - Counter counts ticks of a 128 kHz watchdog oscillator.
// - Restart command restarts the counter before time-out.
// - Always-on fuse forces reset enable one and irq enable zero.
module wdt_mode_control
  import wdt_pkg::*;
#(
  parameter int unsigned OSC_DIV = `WDT_OSC_DIV
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdt_restart,
  input  wire logic        vector_exec,
  input  wire logic        global_irq_en,
  input  wire logic        always_on_fuse,
  input  wire logic        clock_monitor,
  input  wire logic        reset_cause_flag,
  output logic             irq_req,
  output logic             sys_reset_req
);

  apb_state_t  apb_state_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        addr_hit;
  logic        wr_en;
  logic [7:0]  wdata;
  logic [7:0]  ctrl_rd;
  logic        flag_q;
  logic        irq_en_q;
  logic        rst_en_q;
  logic [3:0]  prescale_q;
  logic        chg_q;
  logic [2:0]  chg_cnt_q;
  logic        irq_req_q;
  logic        sys_reset_q;
  wdt_mode_t   mode;
  logic        timeout_evt;
  logic        flag_set;
  logic        flag_clr;
  logic        reset_hit;

  wdt_count_if cif ();

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  assign addr_hit = (paddr == `WDT_CTRL_OFFSET);
  assign wdata    = pwdata[7:0];
  assign wr_en    = (apb_state_q == APB_RESP) && psel && penable && pwrite && addr_hit;
  assign ctrl_rd  = {flag_q, irq_en_q, prescale_q[3], chg_q, rst_en_q, prescale_q[2:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apb_state_q <= APB_IDLE;
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      unique case (apb_state_q)
        APB_IDLE: begin
          if (psel && !penable) begin
            apb_state_q <= APB_RESP;
            pready_q    <= 1'b1;
            pslverr_q   <= !addr_hit;
            prdata_q    <= (addr_hit && !pwrite) ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
          end
        end
        APB_RESP: begin
          apb_state_q <= APB_IDLE;
          pready_q    <= 1'b0;
          pslverr_q   <= 1'b0;
        end
        default: begin
          apb_state_q <= APB_IDLE;
          pready_q    <= 1'b0;
          pslverr_q   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------------
  always_comb begin
    mode = MODE_STOPPED;
    if (clock_monitor) begin
      mode = (always_on_fuse || rst_en_q || irq_en_q) ? MODE_RESET : MODE_STOPPED;
    end else if (always_on_fuse) begin
      mode = MODE_RESET;
    end else begin
      unique case ({rst_en_q, irq_en_q})
        2'b00: mode = MODE_STOPPED;
        2'b01: mode = MODE_IRQ;
        2'b10: mode = MODE_RESET;
        2'b11: mode = MODE_COMBINED;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Counter and event crossing
  // ----------------------------------------------------------------------------
  assign cif.restart      = wdt_restart;
  assign cif.run          = (mode != MODE_STOPPED);
  assign cif.prescale_sel = prescale_q;

  wdt_tick_counter #(
    .OSC_DIV (OSC_DIV)
  ) u_counter (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (cif.cnt)
  );

  wdt_event_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .evt      (cif.timeout),
    .evt_sync (timeout_evt)
  );

  // ----------------------------------------------------------------------------
  // Time-out actions
  // ----------------------------------------------------------------------------
  assign flag_set  = timeout_evt && ((mode == MODE_IRQ) || (mode == MODE_COMBINED && !flag_q));
  assign reset_hit = timeout_evt && ((mode == MODE_RESET) || (mode == MODE_COMBINED && flag_q));
  assign flag_clr  = vector_exec || (wr_en && wdata[`WDT_BIT_FLAG]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_q <= 1'b0;
    end else if (reset_hit) begin
      sys_reset_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= flag_q && irq_en_q && global_irq_en && !clock_monitor && !always_on_fuse;
    end
  end

  // ----------------------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
    end else if (always_on_fuse) begin
      irq_en_q <= 1'b0;
    end else if (vector_exec && rst_en_q) begin
      irq_en_q <= 1'b0;
    end else if (wr_en) begin
      irq_en_q <= wdata[`WDT_BIT_IRQ_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_en_q <= `WDT_RST_EN_RESET;
    end else if (always_on_fuse || reset_cause_flag) begin
      rst_en_q <= 1'b1;
    end else if (wr_en) begin
      if (wdata[`WDT_BIT_RST_EN]) begin
        rst_en_q <= 1'b1;
      end else if (chg_q) begin
        rst_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= `WDT_PSEL_RESET;
    end else if (wr_en && chg_q) begin
      if ({wdata[`WDT_BIT_PSEL_HI], wdata[2:0]} <= `WDT_PSEL_MAX) begin
        prescale_q <= {wdata[`WDT_BIT_PSEL_HI], wdata[2:0]};
      end
    end
  end

  // Change window: open for a fixed count, then closes by itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_q     <= 1'b0;
      chg_cnt_q <= 3'h0;
    end else if (wr_en && wdata[`WDT_BIT_CHANGE_EN]) begin
      chg_q     <= 1'b1;
      chg_cnt_q <= `WDT_CHANGE_EN_CYCLES;
    end else if (chg_q) begin
      chg_cnt_q <= chg_cnt_q - 3'h1;
      if (chg_cnt_q == 3'h1) begin
        chg_q <= 1'b0;
      end
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign irq_req       = irq_req_q;
  assign sys_reset_req = sys_reset_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_flag_irq_mode;
    timeout_evt && (mode == MODE_IRQ) |=> flag_q;
  endproperty
  a_flag_irq_mode: assert property (p_flag_irq_mode) else $error("flag not set in irq mode");

  property p_vector_clears;
    vector_exec && !flag_set |=> !flag_q;
  endproperty
  a_vector_clears: assert property (p_vector_clears) else $error("vector did not clear flag");

  property p_w1c;
    wr_en && pwdata[7] && !flag_set |=> !flag_q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_w0_keeps;
    wr_en && !pwdata[7] && !vector_exec && flag_q |=> flag_q;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared flag");

  property p_irq_cause;
    irq_req |-> $past(flag_q) && $past(irq_en_q) && $past(global_irq_en);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enables");

  property p_irq_only;
    timeout_evt && (mode == MODE_IRQ) && !sys_reset_req |=> !sys_reset_req;
  endproperty
  a_irq_only: assert property (p_irq_only) else $error("reset in irq-only mode");

  property p_combined_first;
    timeout_evt && (mode == MODE_COMBINED) && !flag_q && !sys_reset_req |=> flag_q && !sys_reset_req;
  endproperty
  a_combined_first: assert property (p_combined_first) else $error("first combined timeout wrong");

  property p_combined_vector;
    vector_exec && (mode == MODE_COMBINED) && !timeout_evt |=> !irq_en_q && !flag_q;
  endproperty
  a_combined_vector: assert property (p_combined_vector) else $error("vector left irq enable set");

  property p_combined_reset;
    timeout_evt && (mode == MODE_COMBINED) && flag_q |=> sys_reset_req;
  endproperty
  a_combined_reset: assert property (p_combined_reset) else $error("no reset on second timeout");

  property p_monitor_no_irq;
    $past(clock_monitor) |-> !irq_req;
  endproperty
  a_monitor_no_irq: assert property (p_monitor_no_irq) else $error("irq during clock monitoring");

  property p_monitor_reset;
    timeout_evt && clock_monitor && (rst_en_q || irq_en_q || always_on_fuse) |=> sys_reset_req;
  endproperty
  a_monitor_reset: assert property (p_monitor_reset) else $error("no reset under clock monitoring");

  property p_locked_rst_en;
    wr_en && !chg_q && rst_en_q |=> rst_en_q;
  endproperty
  a_locked_rst_en: assert property (p_locked_rst_en) else $error("reset enable cleared while locked");

  property p_locked_psel;
    wr_en && !chg_q |=> $stable(prescale_q);
  endproperty
  a_locked_psel: assert property (p_locked_psel) else $error("prescale changed while locked");

  property p_chg_window;
    (wr_en && pwdata[4]) ##1 (!(wr_en && pwdata[4]))[*4] |-> chg_q ##1 !chg_q;
  endproperty
  a_chg_window: assert property (p_chg_window) else $error("change window length wrong");

  property p_cause_holds;
    reset_cause_flag |=> rst_en_q;
  endproperty
  a_cause_holds: assert property (p_cause_holds) else $error("reset enable not held");

  property p_fuse_locks;
    always_on_fuse |=> rst_en_q && !irq_en_q;
  endproperty
  a_fuse_locks: assert property (p_fuse_locks) else $error("fuse did not lock mode");

  property p_reset_mode;
    timeout_evt && (mode == MODE_RESET) |=> sys_reset_req;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("no reset in reset mode");

  property p_sync_delay;
    cif.timeout |-> ##2 timeout_evt;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("timeout not passed in two cycles");

  c_irq_mode:    cover property (timeout_evt && mode == MODE_IRQ ##[1:20] irq_req);
  c_combined:    cover property (timeout_evt && mode == MODE_COMBINED && flag_q ##1 sys_reset_req);
  c_chg_used:    cover property (wr_en && pwdata[4] ##[1:4] wr_en && !pwdata[3]);
  c_vector_exec: cover property (vector_exec && mode == MODE_COMBINED);

endmodule : wdt_mode_control

// ### rtl/wdt_pkg.sv
package wdt_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOPPED  = 2'h0,
    MODE_IRQ      = 2'h1,
    MODE_COMBINED = 2'h3,
    MODE_RESET    = 2'h2
  } wdt_mode_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h0,
    APB_RESP = 2'h1
  } apb_state_t;

endpackage : wdt_pkg

// ### rtl/wdt_tick_counter.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_tick_counter #(
  parameter int unsigned OSC_DIV = `WDT_OSC_DIV
) (
  input  wire logic    sys_clk,
  input  wire logic    rst_n,
  wdt_count_if.cnt     cif
);
  logic [`WDT_DIV_W-1:0] div_q;
  logic [`WDT_CNT_W-1:0] cnt_q;
  logic [`WDT_CNT_W-1:0] limit;
  logic                  tick;
  logic                  timeout_q;

  // ----------------------------------------------------------------------------
  // Oscillator tick and time-out count
  // ----------------------------------------------------------------------------
  assign tick  = (div_q == `WDT_DIV_W'(OSC_DIV - 1));
  assign limit = `WDT_BASE_TICKS << cif.prescale_sel;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= '0;
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else if (cif.restart || !cif.run) begin
      div_q     <= '0;
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (tick) begin
        div_q <= '0;
        if ((cnt_q + `WDT_CNT_W'(1)) >= limit) begin
          cnt_q     <= '0;
          timeout_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + `WDT_CNT_W'(1);
        end
      end else begin
        div_q <= div_q + `WDT_DIV_W'(1);
      end
    end
  end

  assign cif.timeout = timeout_q;
endmodule : wdt_tick_counter

// ### test/test_wdt_mode_control.sv
`timescale 1ns/1ps

module test_wdt_mode_control;
  localparam int unsigned OD = 2;
  localparam int          T0 = 2048 * OD;

  logic        sys_clk;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_restart = 1'b0;
  logic        vector_exec = 1'b0;
  logic        global_irq_en = 1'b1;
  logic        always_on_fuse = 1'b0;
  logic        clock_monitor = 1'b0;
  logic        reset_cause_flag = 1'b0;
  logic        irq_req;
  logic        sys_reset_req;
  logic [32:0] exp_q[$];
  logic [7:0]  lfsr_q = 8'h34;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  wdt_mode_control #(.OSC_DIV(OD)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_restart(wdt_restart), .vector_exec(vector_exec), .global_irq_en(global_irq_en),
    .always_on_fuse(always_on_fuse), .clock_monitor(clock_monitor),
    .reset_cause_flag(reset_cause_flag), .irq_req(irq_req), .sys_reset_req(sys_reset_req)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_step

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Expectation noted first, compared by the monitor at pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    lfsr_q = lfsr_step(lfsr_q);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {lfsr_q, 16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] v);
    apb(1'b0, 12'h000, 8'h00, {9'h000, 24'h0, v});
  endtask : rd

  task automatic wr(input logic [7:0] d);
    apb(1'b1, 12'h000, d, 33'h0);
  endtask : wr

  task automatic do_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic pulse_vec;
    @(posedge sys_clk);
    vector_exec <= 1'b1;
    @(posedge sys_clk);
    vector_exec <= 1'b0;
  endtask : pulse_vec

  // Restart, then expect the output quiet early and raised in a bounded window
  task automatic evt(input bit rs, input int t, input string nm);
    int n;
    n = 0;
    @(posedge sys_clk);
    wdt_restart <= 1'b1;
    @(posedge sys_clk);
    wdt_restart <= 1'b0;
    repeat (t - 4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({nm, "_early"}, 33'h0, {32'h0, rs ? sys_reset_req : irq_req});
    while ((rs ? sys_reset_req : irq_req) !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(nm, 33'h1, {32'h0, rs ? sys_reset_req : irq_req});
  endtask : evt

  // --------------------------------------------------------------------------
  // Monitor and timeout
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      chk("apb_resp", exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF, {pslverr, prdata});
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      results();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    do_reset();
    rd(8'h00);
    apb(1'b0, 12'h004, 8'h00, {1'b1, 32'h0});
    apb(1'b1, 12'h008, 8'hFF, {1'b1, 32'h0});
    rd(8'h00);
    $display("test register map done");

    wr(8'h18);
    wr(8'h41);
    rd(8'h41);
    evt(1'b0, 2 * T0, "irq_code1");
    chk("no_reset", 33'h0, {32'h0, sys_reset_req});
    @(posedge sys_clk);
    global_irq_en <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("irq_masked", 33'h0, {32'h0, irq_req});
    rd(8'hC1);
    wr(8'h41);
    rd(8'hC1);
    wr(8'hC1);
    rd(8'h41);
    @(posedge sys_clk);
    global_irq_en <= 1'b1;
    evt(1'b0, 2 * T0, "irq_again");
    pulse_vec();
    rd(8'h41);
    $display("test interrupt mode done");

    do_reset();
    wr(8'h48);
    evt(1'b0, T0, "comb_irq");
    chk("comb_no_reset", 33'h0, {32'h0, sys_reset_req});
    pulse_vec();
    rd(8'h08);
    wr(8'h48);
    evt(1'b0, T0, "comb_again");
    chk("comb_again_no_reset", 33'h0, {32'h0, sys_reset_req});
    pulse_vec();
    rd(8'h08);
    evt(1'b1, T0, "reset_only");
    do_reset();
    wr(8'h48);
    evt(1'b0, T0, "comb_first");
    evt(1'b1, T0, "unserviced");
    $display("test combined mode done");

    do_reset();
    wr(8'h08);
    wr(8'h01);
    rd(8'h08);
    wr(8'h18);
    repeat (4) @(posedge sys_clk);
    wr(8'h00);
    rd(8'h08);
    reset_cause_flag <= 1'b1;
    wr(8'h18);
    wr(8'h00);
    rd(8'h08);
    reset_cause_flag <= 1'b0;
    wr(8'h18);
    wr(8'h2A);
    rd(8'h08);
    always_on_fuse <= 1'b1;
    wr(8'h48);
    rd(8'h08);
    always_on_fuse <= 1'b0;
    $display("test protection done");

    do_reset();
    clock_monitor <= 1'b1;
    wr(8'h40);
    evt(1'b1, T0, "clk_monitor");
    chk("clk_mon_irq", 33'h0, {32'h0, irq_req});
    clock_monitor <= 1'b0;
    do_reset();
    repeat (T0 + 40) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("stopped", 33'h0, {31'h0, irq_req, sys_reset_req});
    $display("test monitor and stopped done");
    results();
  end
endmodule : test_wdt_mode_control
